// [rtl/random_word_generator.v]
// Random word generator with AXI4-Lite register slave and data-ready interrupt
// Register map, byte offsets
// 0x00 generator_control, write-only, key in bits 31:8, enable in bit 0
// 0x10 irq_enable_set, write-only, bit 0 unmasks data-ready
// 0x14 irq_enable_clear, write-only, bit 0 masks data-ready
// 0x18 irq_mask_view, read-only, bit 0 shows the mask
// 0x1c irq_status, cleared on read, bit 0 is data-ready
// 0x50 random_output, read-only, latest complete word
// All registers are 32 bits; unused bits read as zero.
//
// Bus timing
// Write: awready and wready pulse the cycle after valid is seen,
// bvalid follows one cycle after both beats are held.
// Read: arready and rvalid rise together one cycle after arvalid.
// Any other address or access direction answers SLVERR.
// Unmapped reads return zero data with the error response.
// Strobes must all be set for a control write to take effect.
//
// Reset state
// Generator off, interrupt masked, data-ready low, output word zero.
// The shift register reloads its fixed seed on every reset.
//
// Limitations
// The word source is a pseudo-random shift register, not true entropy;
// a silicon noise source would take its place behind the same counter.
// The period counter restarts from zero on every enable.
// Byte strobes are ignored on the interrupt enable registers.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rng_regs.vh"

module random_word_generator #(
    parameter PERIOD = `WORD_PERIOD_CYCLES
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_n_in,
    // AXI4-Lite write address
    input wire s_axi_awvalid_in,
    output reg s_axi_awready_out,
    input wire [7:0] s_axi_awaddr_in,
    // AXI4-Lite write data
    input wire s_axi_wvalid_in,
    output reg s_axi_wready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    // AXI4-Lite write response
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    output reg [1:0] s_axi_bresp_out,
    // AXI4-Lite read address
    input wire s_axi_arvalid_in,
    output reg s_axi_arready_out,
    input wire [7:0] s_axi_araddr_in,
    // AXI4-Lite read data
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    // Interrupt
    output reg irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    // The counter is 8 bits wide, enough for any period up to 256
    reg enable_ff;
    reg irq_mask_ff;
    reg data_ready_flag_ff;
    reg [31:0] random_output_word_ff;
    reg [31:0] lfsr_ff;
    reg [7:0] count_ff;
    reg aw_held_ff;
    reg w_held_ff;
    reg [7:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;

    wire do_write;
    wire do_read;
    wire wr_map;
    wire rd_map;
    wire key_ok;
    wire word_done;
    wire status_read;
    wire [31:0] lfsr_next;
    wire [7:0] period_last;
    wire [31:0] period_full;
    wire key_match;
    wire strobe_full;
    reg [31:0] nxt_rdata;

    // Register hits, each a full 8-bit address compare
    wire wr_ctrl_hit;
    wire wr_ier_hit;
    wire wr_idr_hit;
    wire rd_imr_hit;
    wire rd_isr_hit;
    wire rd_random_output_word_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel capture: address and data accepted in either order
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid_out;
    // Full compare so aliases and misaligned addresses answer SLVERR
    assign wr_ctrl_hit = (awaddr_ff == `GEN_CONTROL_OFF);
    assign wr_ier_hit = (awaddr_ff == `IRQ_ENABLE_SET_OFF);
    assign wr_idr_hit = (awaddr_ff == `IRQ_ENABLE_CLEAR_OFF);
    assign wr_map = wr_ctrl_hit || wr_ier_hit || wr_idr_hit;

    // No new beat is taken while one is held and bvalid stays up until
    // bready, so at most one write is in flight at any time
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= 2'b00;
        end
        else
        begin
            // Ready pulses one cycle per accepted beat
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            if (s_axi_awvalid_in && !aw_held_ff && !s_axi_awready_out)
            begin
                s_axi_awready_out <= 1'b1;
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !w_held_ff && !s_axi_wready_out)
            begin
                s_axi_wready_out <= 1'b1;
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata_in;
                wstrb_ff <= s_axi_wstrb_in;
            end
            if (do_write)
            begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_map ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid_out && s_axi_bready_in)
            begin
                s_axi_bvalid_out <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, answer registered
    // Full compare; write-only offsets read back as SLVERR with zero data
    assign rd_imr_hit = (s_axi_araddr_in == `IRQ_MASK_VIEW_OFF);
    assign rd_isr_hit = (s_axi_araddr_in == `IRQ_STATUS_OFF);
    assign rd_random_output_word_hit = (s_axi_araddr_in == `RANDOM_OUTPUT_OFF);
    assign rd_map = rd_imr_hit || rd_isr_hit || rd_random_output_word_hit;
    assign do_read = s_axi_arvalid_in && !s_axi_arready_out &&
        !s_axi_rvalid_out;
    assign status_read = do_read && rd_isr_hit;

    // Read data select; anything unmapped returns zero
    always @*
    begin
        nxt_rdata = 32'h00000000;
        if (rd_imr_hit)
            nxt_rdata[`DATA_READY_BIT] = irq_mask_ff;
        else if (rd_isr_hit)
            nxt_rdata[`DATA_READY_BIT] = data_ready_flag_ff;
        else if (rd_random_output_word_hit)
            nxt_rdata = random_output_word_ff;
    end

    // rvalid holds with its data until rready and no address is
    // taken meanwhile, so reads never overlap
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= 2'b00;
        end
        else
        begin
            s_axi_arready_out <= do_read;
            if (do_read)
            begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= rd_map ? 2'b00 : 2'b10;
                s_axi_rdata_out <= nxt_rdata;
            end
            else if (s_axi_rvalid_out && s_axi_rready_in)
                s_axi_rvalid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and interrupt mask; key guards every generator enable change, not the mask writes
    // Partial strobes could tear the key, so all four lanes must be set
    // A wrong key is answered OKAY but changes nothing
    assign key_match = (wdata_ff[31:8] == `CTRL_KEY_VALUE);
    assign strobe_full = &wstrb_ff;
    assign key_ok = key_match && strobe_full;

    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            enable_ff <= 1'b0;
            irq_mask_ff <= 1'b0;
        end
        else if (do_write)
        begin
            if (wr_ctrl_hit && key_ok)
                enable_ff <= wdata_ff[`CTRL_ENABLE_BIT];
            if (wr_ier_hit && wdata_ff[`DATA_READY_BIT])
                irq_mask_ff <= 1'b1;
            else if (wr_idr_hit && wdata_ff[`DATA_READY_BIT])
                irq_mask_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word engine: a 32-bit LFSR stands in for the entropy source
    // Pseudo-random only; a silicon source would replace this register
    assign lfsr_next = {lfsr_ff[30:0],
        lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
    // Counter end point; PERIOD must stay within 2 to 256
    // A word completes on the last count, then the counter restarts
    assign period_full = PERIOD - 1;
    assign period_last = period_full[7:0];
    assign word_done = enable_ff && (count_ff == period_last);

    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            lfsr_ff <= `LFSR_SEED;
            count_ff <= 8'h00;
            random_output_word_ff <= `RANDOM_OUTPUT_RESET;
        end
        else
        begin
            // Source keeps stirring even when idle for less predictability
            lfsr_ff <= lfsr_next;
            if (!enable_ff)
                count_ff <= 8'h00;
            else if (word_done)
                count_ff <= 8'h00;
            else
                count_ff <= count_ff + 8'h01;
            if (word_done)
                random_output_word_ff <= lfsr_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data-ready flag: a new word wins over a status read in the same cycle
    // Disabling clears it at once so a stale word is never flagged
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            data_ready_flag_ff <= 1'b0;
        else if (word_done)
            data_ready_flag_ff <= 1'b1;
        else if (!enable_ff || status_read)
            data_ready_flag_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output, registered
    // Built from the flag's next value gated by irq_mask_ff, so it follows the flag while unmasked
    // and the pin comes straight from a flip-flop
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            irq_out <= 1'b0;
        else
            irq_out <= (word_done || (data_ready_flag_ff && enable_ff &&
                !status_read)) && irq_mask_ff;
    end

endmodule // random_word_generator

// [rtl/rng_regs.vh]
// Register map, field positions and timing constants of the random word generator
`ifndef RNG_REGS_VH
`define RNG_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets
`define GEN_CONTROL_OFF 8'h00
`define IRQ_ENABLE_SET_OFF 8'h10
`define IRQ_ENABLE_CLEAR_OFF 8'h14
`define IRQ_MASK_VIEW_OFF 8'h18
`define IRQ_STATUS_OFF 8'h1c
`define RANDOM_OUTPUT_OFF 8'h50

////////////////////////////////////////////////////////////////////////////////
// Fields
`define CTRL_ENABLE_BIT 0
`define CTRL_KEY_VALUE 24'h524e47
`define DATA_READY_BIT 0

////////////////////////////////////////////////////////////////////////////////
// Timing and reset values
`define WORD_PERIOD_CYCLES 84
`define RANDOM_OUTPUT_RESET 32'h00000000
`define LFSR_SEED 32'h1d872b41

`endif

// [verif/random_word_generator_bench.sv]
// Self-checking bench for the random word generator
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
    num_errors = num_errors + 1; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module random_word_generator_bench;
    reg clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    reg [7:0] aw = 8'h0, ar = 8'h0;
    reg [31:0] wd = 32'h0, d, d1, d2;
    wire awr, wrdy, bv, arr, rv, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer num_errors = 0, n_tests = 0, cyc = 0, t1, t2;
    random_word_generator dut (.ref_clk_in(clk), .rst_n_in(rst_n),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(aw), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ar), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .irq_out(irq));
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////
    // Bus tasks; each starts on a fresh edge so no signal is set twice
    task wrt(input [7:0] a, input [31:0] v, input [1:0] er);
        integer t;
        begin
            @(posedge clk);
            aw <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1; t = 0;
            do
            begin
                @(posedge clk);
                t = t + 1;
                if (awr) awv <= 1'b0;
                if (wrdy) wv <= 1'b0;
            end while (!bv && t < 60);
            if (t >= 60) num_errors = num_errors + 1;
            br <= 1'b0;
            `CHK(bresp, er)
        end
    endtask
    task rdt(input [7:0] a, input [1:0] er, output [31:0] v);
        integer t;
        begin
            @(posedge clk);
            ar <= a; arv <= 1'b1; rr <= 1'b1; t = 0;
            do
            begin
                @(posedge clk);
                t = t + 1;
                if (arr) arv <= 1'b0;
            end while (!rv && t < 60);
            if (t >= 60) num_errors = num_errors + 1;
            rr <= 1'b0;
            v = rdata;
            `CHK(rresp, er)
        end
    endtask
    task rdc(input [7:0] a, input [31:0] ev);
        begin
            rdt(a, 2'b00, d);
            `CHK(d, ev)
        end
    endtask
    // Bounded wait for the interrupt, giving up after 300 cycles
    task wirq;
        integer t;
        begin
            t = 0;
            while (irq !== 1'b1 && t < 300)
            begin
                @(posedge clk);
                t = t + 1;
            end
        end
    endtask
    task print_verdict;
        begin
            if (num_errors == 0 && n_tests > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h18, 32'h0);
        rdc(8'h1c, 32'h0);
        rdc(8'h50, 32'h0);
        rdt(8'h20, 2'b10, d);
        rdt(8'h58, 2'b10, d);
        `CHK(d, 32'h0)
        rdt(8'h00, 2'b10, d);
        wrt(8'h00, 32'h12345601, 2'b00);
        repeat (200) @(posedge clk);
        rdc(8'h1c, 32'h0);
        wrt(8'h10, 32'h0, 2'b00);
        rdc(8'h18, 32'h0);
        wrt(8'h10, 32'h1, 2'b00);
        rdc(8'h18, 32'h1);
        wrt(8'h00, 32'h524e4701, 2'b00);
        wirq;
        t1 = cyc;
        `CHK(irq, 1'b1)
        rdc(8'h1c, 32'h1);
        rdt(8'h50, 2'b00, d1);
        rdc(8'h1c, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wirq;
        t2 = cyc;
        `CHK(t2 - t1, 32'h54)
        rdc(8'h1c, 32'h1);
        rdt(8'h50, 2'b00, d2);
        `CHK(d1 != d2, 1'b1)
        wrt(8'h14, 32'h0, 2'b00);
        rdc(8'h18, 32'h1);
        wrt(8'h14, 32'h1, 2'b00);
        rdc(8'h18, 32'h0);
        repeat (100) @(posedge clk);
        `CHK(irq, 1'b0)
        rdc(8'h1c, 32'h1);
        wrt(8'h50, 32'h1, 2'b10);
        wrt(8'h00, 32'h524e4700, 2'b00);
        rdc(8'h1c, 32'h0);
        repeat (200) @(posedge clk);
        rdc(8'h1c, 32'h0);
        print_verdict;
    end
    // Watchdog well past the expected run of about a thousand cycles
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        print_verdict;
    end
endmodule // random_word_generator_bench

// [verif/random_word_generator_checker.sv]
// Bus and interrupt assertions for the random word generator
`timescale 1ns/1ps
module rng_checker #(
    parameter PERIOD = 84
) (
    // Clock, reset, interrupt and bus signals
    input wire ref_clk_in, rst_n_in, irq_out,
    input wire s_axi_awready_out, s_axi_wready_out, s_axi_bready_in,
    input wire s_axi_bvalid_out, s_axi_arvalid_in, s_axi_arready_out,
    input wire s_axi_rvalid_out, s_axi_rready_in,
    input wire [7:0] s_axi_awaddr_in, s_axi_araddr_in,
    input wire [1:0] s_axi_bresp_out, s_axi_rresp_out,
    input wire [31:0] s_axi_rdata_out
);
    reg irq_d_ff;
    reg arm_ff;
    reg [8:0] gap_ff;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////
    // Gap between interrupt rises; any write may shift the word phase
    always @(posedge ref_clk_in)
    begin
        irq_d_ff <= irq_out;
        gap_ff <= (irq_out && !irq_d_ff) ? 9'h1 : gap_ff + 9'h1;
        if (!rst_n_in || s_axi_awready_out)
            arm_ff <= 1'b0;
        else if (irq_out && !irq_d_ff)
            arm_ff <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Properties
    a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("b");
    a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("r");
    a_arready_pulse: assert property (s_axi_arready_out
        |=> !s_axi_arready_out) else $error("arready");
    a_read_answer: assert property (s_axi_arvalid_in && !s_axi_arready_out
        && !s_axi_rvalid_out |=> s_axi_arready_out && s_axi_rvalid_out)
        else $error("no read answer");
    a_write_answer: assert property (s_axi_awready_out && s_axi_wready_out
        |=> s_axi_bvalid_out) else $error("no write answer");
    a_ro_write_err: assert property (s_axi_awready_out && s_axi_wready_out
        && s_axi_awaddr_in == 8'h50 |=> s_axi_bresp_out == 2'b10)
        else $error("ro write");
    a_unmapped_read: assert property (s_axi_arready_out && s_axi_araddr_in
        == 8'h20 |-> s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0)
        else $error("unmapped read");
    a_irq_read_clear: assert property (
        s_axi_arready_out && s_axi_araddr_in == 8'h1c |-> ##[1:2] !irq_out)
        else $error("irq not cleared");
    a_word_period: assert property (
        irq_out && !irq_d_ff && arm_ff |-> gap_ff == PERIOD)
        else $error("word period");
    cover property ($rose(irq_out));
    cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'b10);
    cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'b10);
endmodule // rng_checker

bind random_word_generator rng_checker #(.PERIOD(PERIOD)) u_chk (.*);
